// ### hw/qrsc_pkg.sv
// Package: constants, types and register map of the quasi-resonant switch control block
package qrsc_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS           = 25;
	localparam int unsigned MIN_SWITCH_FREQ_HZ      = 20000;
	localparam int unsigned MAX_OFF_TIME_NS         = 1000000000 / MIN_SWITCH_FREQ_HZ;
	localparam int unsigned SHORT_RING_SUPPRESS_NS  = 2500;
	localparam int unsigned LONG_RING_SUPPRESS_NS   = 25000;
	localparam int unsigned LEAD_EDGE_BLANK_NS      = 250;
	localparam int unsigned MAX_ON_TIME_NS          = 30000;
	localparam int unsigned SEL_SOURCE_OFF_US       = 2;
	localparam int unsigned BURST_ENTRY_BLANK_MS    = 20;
	localparam int unsigned EVAL_PERIOD_MS          = 48;

	// Longest times round down, least times round up, never below one cycle
	localparam int unsigned MAX_OFF_CYC   = (MAX_OFF_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
	                                        : MAX_OFF_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned RS_SHORT_CYC  = (SHORT_RING_SUPPRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RS_LONG_CYC   = (LONG_RING_SUPPRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LEB_CYC       = (LEAD_EDGE_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MAX_ON_CYC    = (MAX_ON_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
	                                        : MAX_ON_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned SEL_OFF_CYC   = (SEL_SOURCE_OFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BURST_BLANK_CYC = (BURST_ENTRY_BLANK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EVAL_CYC      = (EVAL_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

	// Valley counts
	localparam logic [3:0] CNT_MIN_LOW   = 4'h1;
	localparam logic [3:0] CNT_MIN_HIGH  = 4'h3;
	localparam logic [3:0] CNT_MAX_LOW   = 4'h8;
	localparam logic [3:0] CNT_MAX_HIGH  = 4'hA;

	// Register map
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_COUNTS   = 12'h008;
	localparam logic        CTRL_RESET   = 1'h1;
	localparam int unsigned CTRL_EN_BIT  = 0;

	// Analog comparator outputs, each high when its condition holds
	typedef struct packed {
		logic ref_good;          // Reference good, supply above 4 V
		logic vcc_on;            // Supply at or above turn-on threshold
		logic fb_above_sel_ref;  // Feedback above level-select reference
		logic high_line;         // Bus voltage above line reference
		logic zcd_above_rs;      // Valley pin above ringing_voltage_threshold
		logic zcd_above_ct;      // Valley pin above valley_crossing_threshold
		logic cs_over_fb;        // Scaled current sense above feedback
		logic cs_over_peak;      // Current sense above peak limit
		logic cs_over_bl_low;    // Current above burst_current_limit_low
		logic cs_over_bl_high;   // Current above burst_current_limit_high
		logic fb_above_lhc;      // Feedback above hold threshold
		logic fb_above_hlc;      // Feedback above count-down threshold
		logic fb_above_r;        // Feedback above counter reset threshold
		logic fb_below_entry1;   // Feedback below level one burst_entry_threshold
		logic fb_below_entry2;   // Feedback below level two burst_entry_threshold
		logic fb_above_bon;      // Feedback above burst_on_threshold
		logic fb_below_boff;     // Feedback at or below burst_off_threshold
		logic fb_above_exit;     // Feedback above burst_exit_threshold
	} qrsc_cmp_t;

	typedef enum logic [2:0] {
		ST_OFF      = 3'b000,
		ST_ON       = 3'b001,
		ST_SUPPRESS = 3'b010,
		ST_VALLEY   = 3'b011,
		ST_PAUSE    = 3'b100
	} qrsc_state_t;

endpackage : qrsc_pkg

// ### hw/qrsc_switch_ctrl.sv
// Gate timing, valley counting, up/down counter and burst control with APB registers
`timescale 1ns/100ps
`default_nettype none

module qrsc_switch_ctrl #(
	parameter int unsigned RS_SHORT_CYCLES  = qrsc_pkg::RS_SHORT_CYC,
	parameter int unsigned RS_LONG_CYCLES   = qrsc_pkg::RS_LONG_CYC,
	parameter int unsigned LEB_CYCLES       = qrsc_pkg::LEB_CYC,
	parameter int unsigned MAX_ON_CYCLES    = qrsc_pkg::MAX_ON_CYC,
	parameter int unsigned MAX_OFF_CYCLES   = qrsc_pkg::MAX_OFF_CYC,
	parameter int unsigned SEL_OFF_CYCLES   = qrsc_pkg::SEL_OFF_CYC,
	parameter int unsigned BURST_BLANK_CYCLES = qrsc_pkg::BURST_BLANK_CYC,
	parameter int unsigned EVAL_CYCLES      = qrsc_pkg::EVAL_CYC
) (
	input  wire logic              pclk,              // 40 MHz clock
	input  wire logic              presetn,           // Asynchronous reset, active low
	input  wire logic              psel,              // APB select
	input  wire logic              penable,           // APB enable
	input  wire logic              pwrite,            // APB write
	input  wire logic [11:0]       paddr,             // APB byte address
	input  wire logic [31:0]       pwdata,            // APB write data
	output logic [31:0]            prdata,            // APB read data
	output logic                   pready,            // APB ready
	output logic                   pslverr,           // APB error on unmapped address
	input  wire qrsc_pkg::qrsc_cmp_t cmp,             // Raw comparator outputs
	output logic                   gate,              // Power switch gate drive
	output logic                   fb_pullup_en,      // internal_feedback_pullup connected
	output logic                   sel_source_en,     // Level-select current source on
	output logic                   level_two,         // Burst level two selected
	output logic                   burst_active,      // In active burst mode
	output logic                   peak_limit_high    // Selects high-line peak limit
);

	localparam int unsigned CW = $bits(qrsc_pkg::qrsc_cmp_t);

	function automatic logic [3:0] cnt_min(input logic hl);
		cnt_min = hl ? qrsc_pkg::CNT_MIN_HIGH : qrsc_pkg::CNT_MIN_LOW;
	endfunction : cnt_min

	function automatic logic [3:0] cnt_max(input logic hl);
		cnt_max = hl ? qrsc_pkg::CNT_MAX_HIGH : qrsc_pkg::CNT_MAX_LOW;
	endfunction : cnt_max

	// Comparator synchronizers
	logic [CW-1:0]          sync1_q;
	logic [CW-1:0]          sync2_q;
	qrsc_pkg::qrsc_cmp_t    s;
	logic                   zcd_ct_prev_q;
	logic                   vcc_on_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= cmp;
			sync2_q <= sync1_q;
		end
	end
	assign s = qrsc_pkg::qrsc_cmp_t'(sync2_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zcd_ct_prev_q <= 1'b0;
			vcc_on_prev_q <= 1'b0;
		end else begin
			zcd_ct_prev_q <= s.zcd_above_ct;
			vcc_on_prev_q <= s.vcc_on;
		end
	end

	// Registers
	logic                   ctrl_en_q;
	logic [31:0]            prdata_q;
	logic                   wr_ctrl;
	logic                   mapped;

	assign mapped  = (paddr == qrsc_pkg::REG_CTRL) || (paddr == qrsc_pkg::REG_STATUS)
	                 || (paddr == qrsc_pkg::REG_COUNTS);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_ctrl = psel && penable && pwrite && (paddr == qrsc_pkg::REG_CTRL);
	assign prdata  = prdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_q <= qrsc_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_en_q <= pwdata[qrsc_pkg::CTRL_EN_BIT];
		end
	end

	// Detection latch and feedback pin configuration
	logic                   latch_q;
	logic                   level_two_q;
	logic                   sel_src_q;
	logic [7:0]             sel_cnt_q;
	logic                   dev_on;

	assign dev_on = s.vcc_on && latch_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_q     <= 1'b0;
			level_two_q <= 1'b0;
		end else if (!s.ref_good) begin
			latch_q     <= 1'b0;
		end else if (s.vcc_on && !vcc_on_prev_q && !latch_q) begin
			latch_q     <= 1'b1;
			level_two_q <= !s.fb_above_sel_ref;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_src_q <= 1'b1;
			sel_cnt_q <= '0;
		end else if (!latch_q) begin
			sel_src_q <= 1'b1;
			sel_cnt_q <= '0;
		end else if (sel_src_q) begin
			if (32'(sel_cnt_q) + 32'd1 >= SEL_OFF_CYCLES) begin
				sel_src_q <= 1'b0;
			end
			sel_cnt_q <= sel_cnt_q + 8'h01;
		end
	end
	assign sel_source_en = sel_src_q;
	assign fb_pullup_en  = !sel_src_q;
	assign level_two     = level_two_q;

	// Line- and level-dependent selections
	logic                   hl;
	logic                   hl_prev_q;
	logic [3:0]             ud_q;
	logic                   burst_q;
	logic                   paused_q;
	logic                   entry_low;
	logic                   cs_burst_lim;

	assign hl              = s.high_line;
	assign peak_limit_high = hl;
	assign entry_low       = level_two_q ? s.fb_below_entry2 : s.fb_below_entry1;
	assign cs_burst_lim    = level_two_q ? s.cs_over_bl_high : s.cs_over_bl_low;
	assign burst_active    = burst_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hl_prev_q <= 1'b0;
		end else begin
			hl_prev_q <= hl;
		end
	end

	// Up/down counter, evaluated once per period
	logic [21:0]            eval_cnt_q;
	logic                   seen_lhc_q;
	logic                   seen_hlc_q;
	logic                   seen_r_q;
	logic                   eval_tick;
	logic                   burst_exit;

	assign eval_tick = (32'(eval_cnt_q) + 32'd1 >= EVAL_CYCLES);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eval_cnt_q <= '0;
			seen_lhc_q <= 1'b0;
			seen_hlc_q <= 1'b0;
			seen_r_q   <= 1'b0;
		end else if (eval_tick) begin
			eval_cnt_q <= '0;
			seen_lhc_q <= 1'b0;
			seen_hlc_q <= 1'b0;
			seen_r_q   <= 1'b0;
		end else begin
			eval_cnt_q <= eval_cnt_q + 22'h000001;
			seen_lhc_q <= seen_lhc_q || s.fb_above_lhc;
			seen_hlc_q <= seen_hlc_q || s.fb_above_hlc;
			seen_r_q   <= seen_r_q || s.fb_above_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ud_q <= qrsc_pkg::CNT_MIN_LOW;
		end else if (!dev_on || hl != hl_prev_q || burst_exit) begin
			ud_q <= cnt_min(hl);
		end else if (eval_tick && !burst_q) begin
			if (seen_r_q || s.fb_above_r) begin
				ud_q <= cnt_min(hl);
			end else if (seen_hlc_q || s.fb_above_hlc) begin
				if (ud_q > cnt_min(hl)) begin
					ud_q <= ud_q - 4'h1;
				end
			end else if (!(seen_lhc_q || s.fb_above_lhc)) begin
				if (ud_q < cnt_max(hl)) begin
					ud_q <= ud_q + 4'h1;
				end
			end
		end
	end

	// Burst mode
	logic [22:0]            blank_cnt_q;
	logic                   entry_ok;

	assign entry_ok   = entry_low && (ud_q == cnt_max(hl));
	assign burst_exit = burst_q && s.fb_above_exit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_cnt_q <= '0;
		end else if (burst_q || !entry_ok || !dev_on) begin
			blank_cnt_q <= '0;
		end else if (32'(blank_cnt_q) < BURST_BLANK_CYCLES) begin
			blank_cnt_q <= blank_cnt_q + 23'h000001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_q  <= 1'b0;
			paused_q <= 1'b0;
		end else if (!dev_on || burst_exit) begin
			burst_q  <= 1'b0;
			paused_q <= 1'b0;
		end else if (!burst_q) begin
			if (entry_ok && 32'(blank_cnt_q) >= BURST_BLANK_CYCLES) begin
				burst_q  <= 1'b1;
				paused_q <= 1'b1;
			end
		end else if (paused_q) begin
			if (s.fb_above_bon) begin
				paused_q <= 1'b0;
			end
		end else if (s.fb_below_boff) begin
			paused_q <= 1'b1;
		end
	end

	// Gate state machine
	qrsc_pkg::qrsc_state_t  st_q;
	logic [15:0]            tmr_q;
	logic [15:0]            off_cnt_q;
	logic [3:0]             valley_q;
	logic [3:0]             target;
	logic                   run;
	logic                   turn_off;
	logic                   valley_edge;

	assign run         = dev_on && ctrl_en_q && !(burst_q && paused_q);
	assign target      = burst_q ? cnt_max(hl) : ud_q;
	assign valley_edge = zcd_ct_prev_q && !s.zcd_above_ct;
	// Blanking covers the feedback and burst comparisons; the peak limit stays live as a last resort
	assign turn_off    = s.cs_over_peak
	                     || (32'(tmr_q) + 32'd1 > MAX_ON_CYCLES)
	                     || (32'(tmr_q) >= LEB_CYCLES
	                         && (burst_q ? cs_burst_lim : s.cs_over_fb));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= qrsc_pkg::ST_OFF;
			tmr_q     <= '0;
			off_cnt_q <= '0;
		end else begin
			case (st_q)
				qrsc_pkg::ST_OFF: begin
					if (run) begin
						st_q  <= qrsc_pkg::ST_ON;
						tmr_q <= '0;
					end
				end
				qrsc_pkg::ST_ON: begin
					tmr_q <= tmr_q + 16'h0001;
					if (turn_off || !run) begin
						st_q      <= run ? qrsc_pkg::ST_SUPPRESS : qrsc_pkg::ST_PAUSE;
						tmr_q     <= '0;
						off_cnt_q <= 16'h0001;
					end
				end
				qrsc_pkg::ST_SUPPRESS: begin
					tmr_q     <= tmr_q + 16'h0001;
					off_cnt_q <= off_cnt_q + 16'h0001;
					if (!run) begin
						st_q <= qrsc_pkg::ST_PAUSE;
					end else if (32'(tmr_q) + 32'd1 >= (s.zcd_above_rs ? RS_SHORT_CYCLES : RS_LONG_CYCLES)) begin
						st_q <= qrsc_pkg::ST_VALLEY;
					end
				end
				qrsc_pkg::ST_VALLEY: begin
					off_cnt_q <= off_cnt_q + 16'h0001;
					if (!run) begin
						st_q <= qrsc_pkg::ST_PAUSE;
					end else if (valley_q == target || 32'(off_cnt_q) >= MAX_OFF_CYCLES) begin
						st_q  <= qrsc_pkg::ST_ON;
						tmr_q <= '0;
					end
				end
				qrsc_pkg::ST_PAUSE: begin
					if (run) begin
						st_q  <= qrsc_pkg::ST_ON;
						tmr_q <= '0;
					end
				end
				default: begin
					st_q <= qrsc_pkg::ST_OFF;
				end
			endcase
		end
	end

	assign gate = (st_q == qrsc_pkg::ST_ON);

	// Valley counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valley_q <= '0;
		end else if (st_q == qrsc_pkg::ST_ON) begin
			valley_q <= '0;
		end else if (valley_edge && valley_q != 4'hF) begin
			valley_q <= valley_q + 4'h1;
		end
	end

	// Read data is latched in the setup phase, so every access completes without wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (psel && !penable) begin
			case (paddr)
				qrsc_pkg::REG_CTRL:   prdata_q <= {31'h0, ctrl_en_q};
				qrsc_pkg::REG_STATUS: prdata_q <= {22'h0, st_q, hl, level_two_q, latch_q,
				                                   paused_q, burst_q, gate, sel_src_q};
				qrsc_pkg::REG_COUNTS: prdata_q <= {24'h0, valley_q, ud_q};
				default:              prdata_q <= '0;
			endcase
		end
	end

endmodule : qrsc_switch_ctrl

`default_nettype wire

// ### verif/qrsc_switch_ctrl_monitor.sv
// Checker of gate timing, burst control and level detection
`timescale 1ns/100ps
`default_nettype none
module qrsc_switch_ctrl_monitor #(
	parameter int unsigned MAX_ON_CYCLES  = 40,
	parameter int unsigned MAX_OFF_CYCLES = 300
) (
	input wire logic                pclk,          // Clock
	input wire logic                presetn,       // Reset, active low
	input wire qrsc_pkg::qrsc_cmp_t cmp,           // Comparators
	input wire logic                gate,          // Gate drive
	input wire logic                fb_pullup_en,  // Pull-up on
	input wire logic                sel_source_en, // Select source on
	input wire logic                level_two,     // Level two
	input wire logic                burst_active   // Burst mode
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [15:0] on_q;
	logic [15:0] off_q;
	logic        ent;
	assign ent = level_two ? cmp.fb_below_entry2 : cmp.fb_below_entry1;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_q  <= 16'h0;
			off_q <= 16'h0;
		end else begin
			on_q  <= gate ? on_q + 16'h1 : 16'h0;
			// Pause and device off stretch the off-time legally
			off_q <= (gate || burst_active || !fb_pullup_en || !cmp.vcc_on || !cmp.ref_good) ? 16'h0
			         : off_q + 16'h1;
		end
	end
	AST_RING_HOLD: assert property ($fell(gate) |-> !gate [*4])
		else $error("gate rose inside suppression");
	// Device-off and burst pause may legally cut a pulse short
	AST_MIN_ON: assert property ($rose(gate) && !cmp.cs_over_peak && cmp.vcc_on && cmp.ref_good
		&& !(burst_active && cmp.fb_below_boff) |-> gate [*3])
		else $error("pulse shorter than blanking");
	AST_MAX_ON: assert property (gate |-> 32'(on_q) <= MAX_ON_CYCLES + 1)
		else $error("on-time too long");
	AST_MAX_OFF: assert property (32'(off_q) <= MAX_OFF_CYCLES + 3)
		else $error("off-time too long");
	AST_PEAK_OFF: assert property (gate && cmp.cs_over_peak |-> ##[1:4] !gate)
		else $error("peak limit ignored");
	AST_FB_OFF: assert property (gate && cmp.cs_over_fb && !burst_active && on_q > 16'h3 |-> ##[1:4] !gate)
		else $error("feedback turn-off missing");
	AST_LATCH_CLR: assert property ((!cmp.ref_good && !cmp.vcc_on) [*5] |-> sel_source_en && !fb_pullup_en)
		else $error("detection latch not cleared");
	AST_PULLUP_SWAP: assert property (!cmp.ref_good [*4] |=> sel_source_en && !fb_pullup_en)
		else $error("pull-up and source overlap");
	AST_SRC_OFF: assert property ($rose(cmp.vcc_on) && cmp.ref_good && sel_source_en |-> ##[80:88] !sel_source_en)
		else $error("select source not released");
	AST_LEVEL_HOLD: assert property (!sel_source_en && cmp.ref_good |-> $stable(level_two))
		else $error("level changed after detection");
	AST_BURST_ENTRY: assert property ($rose(burst_active) |-> $past(ent, 4))
		else $error("burst entered without entry level");
	AST_BURST_EXIT: assert property (burst_active && cmp.fb_above_exit |-> ##[1:4] !burst_active)
		else $error("burst not left");
	AST_PAUSE_LOW: assert property ((burst_active && !gate && cmp.fb_below_boff) [*4] |=> !gate)
		else $error("switching while paused");
	cover property ($rose(burst_active));
	cover property ($fell(burst_active));
	cover property ($fell(sel_source_en));
endmodule : qrsc_switch_ctrl_monitor
bind qrsc_switch_ctrl qrsc_switch_ctrl_monitor #(
	.MAX_ON_CYCLES (MAX_ON_CYCLES),
	.MAX_OFF_CYCLES(MAX_OFF_CYCLES)
) i_mon (
	.pclk         (pclk),
	.presetn      (presetn),
	.cmp          (cmp),
	.gate         (gate),
	.fb_pullup_en (fb_pullup_en),
	.sel_source_en(sel_source_en),
	.level_two    (level_two),
	.burst_active (burst_active)
);
`default_nettype wire

// ### verif/qrsc_analog_model.sv
// Behavioural comparators on feedback, current sense and valley pin
`timescale 1ns/100ps
`default_nettype none
module qrsc_analog_model #(
	parameter int SEL_REF = 1500, // Arbitrary levels in mV
	parameter int LHC     = 1200,
	parameter int HLC     = 1400,
	parameter int RST     = 1600,
	parameter int BOFF    = 2000,
	parameter int BON     = 2400,
	parameter int BL1     = 6,    // Ramp cycles to burst limits
	parameter int BL2     = 8,
	parameter int HALF    = 8     // Half period of ringing
) (
	input wire logic            pclk,   // Clock
	input wire logic            gate,   // Gate drive
	input wire logic [11:0]     fb_mv,  // Feedback, mV
	input wire logic            ring,   // Ringing present
	input wire logic            rs_hi,  // Above ring threshold
	input wire logic            hl,     // High line
	input wire logic            rg,     // Reference good
	input wire logic            von,    // Supply at turn-on
	input wire logic [7:0]      ton_fb, // Ramp cycles to feedback
	input wire logic [7:0]      ton_pk, // Ramp cycles to peak
	output qrsc_pkg::qrsc_cmp_t cmp     // Comparator levels
);
	logic [7:0] cs_q = 8'h0;
	logic [7:0] rc_q = 8'h0;
	logic       zc_q = 1'b1;
	int         f;
	assign f = int'(fb_mv);
	// Current ramps only while on; gate drive pulls the valley pin high
	always_ff @(posedge pclk) begin
		cs_q <= gate ? cs_q + 8'h1 : 8'h0;
		rc_q <= (gate || !ring || 32'(rc_q) == HALF - 1) ? 8'h0 : rc_q + 8'h1;
		zc_q <= gate ? 1'b1 : (ring && 32'(rc_q) == HALF - 1) ? !zc_q : zc_q;
	end
	always_comb begin
		cmp                  = '0;
		cmp.ref_good         = rg;
		cmp.vcc_on           = von;
		cmp.fb_above_sel_ref = f > SEL_REF;
		cmp.high_line        = hl;
		cmp.zcd_above_rs     = rs_hi;
		cmp.zcd_above_ct     = zc_q;
		cmp.cs_over_fb       = gate && cs_q >= ton_fb;
		cmp.cs_over_peak     = gate && cs_q >= ton_pk;
		cmp.cs_over_bl_low   = gate && 32'(cs_q) >= BL1;
		cmp.cs_over_bl_high  = gate && 32'(cs_q) >= BL2;
		cmp.fb_above_lhc     = f > LHC;
		cmp.fb_above_hlc     = f > HLC;
		cmp.fb_above_r       = f > RST;
		cmp.fb_below_entry1  = f < 900;
		cmp.fb_below_entry2  = f < 1050;
		cmp.fb_above_bon     = f > BON;
		cmp.fb_below_boff    = f <= BOFF;
		cmp.fb_above_exit    = f > 2750;
	end
endmodule : qrsc_analog_model
`default_nettype wire

// ### verif/qrsc_switch_ctrl_tb_top.sv
// Testbench of the switch control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin \
	checked++; \
	if ((a) !== (e)) begin \
		n_fail++; \
		$display("Error at %0t: got %0h expected %0h", $time, a, e); \
	end \
end
module qrsc_switch_ctrl_tb_top;
	logic                pclk = 1'b0, presetn = 1'b0;
	logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]         paddr = 12'h0;
	logic [31:0]         pwdata = 32'h0, prdata, r;
	logic                pready, pslverr, e;
	qrsc_pkg::qrsc_cmp_t cmp;
	logic                gate, fb_pullup_en, sel_source_en, level_two, burst_active, peak_limit_high;
	logic [11:0]         fb = 12'd2000;
	logic                ring = 1'b1, rs = 1'b1, hl = 1'b0, rg = 1'b0, von = 1'b0;
	logic [7:0]          tfb = 8'd20, tpk = 8'd200;
	int                  n_fail = 0, checked = 0, cyc = 0, h, l, n;
	qrsc_switch_ctrl #(
		.RS_SHORT_CYCLES(4),
		.LEB_CYCLES(3),
		.MAX_ON_CYCLES(40),
		.BURST_BLANK_CYCLES(20),
		.EVAL_CYCLES(50)
	) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp(cmp), .gate(gate), .fb_pullup_en(fb_pullup_en), .sel_source_en(sel_source_en),
		.level_two(level_two), .burst_active(burst_active), .peak_limit_high(peak_limit_high));
	qrsc_analog_model i_model (.pclk(pclk), .gate(gate), .fb_mv(fb), .ring(ring), .rs_hi(rs),
		.hl(hl), .rg(rg), .von(von), .ton_fb(tfb), .ton_pk(tpk), .cmp(cmp));
	initial begin
		forever #12.5 pclk = !pclk;
	end
	task automatic w(input int k);
		repeat (k) @(posedge pclk);
	endtask : w
	task automatic smp();
		@(posedge pclk);
		#1;
	endtask : smp
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Skips a partial pulse, then measures one whole period
	task automatic per();
		h = 0;
		l = 0;
		smp();
		while (gate === 1'b1) smp();
		while (gate !== 1'b1) smp();
		while (gate === 1'b1) begin
			smp();
			h++;
		end
		while (gate !== 1'b1) begin
			smp();
			l++;
		end
		@(posedge pclk);
	endtask : per
	task automatic quiet();
		n = 0;
		repeat (50) begin
			smp();
			n += int'(gate !== 1'b0);
		end
		@(posedge pclk);
	endtask : quiet
	task final_report();
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		w(8);
		presetn <= 1'b1;
		w(1);
		rg <= 1'b1;
		w(4);
		von <= 1'b1;
		w(100);
		smp();
		`CHK({sel_source_en, fb_pullup_en, level_two}, 3'b010)
		w(1);
		fb <= 12'd500;
		w(10);
		apb(1'b0, qrsc_pkg::REG_STATUS, 32'h0);
		`CHK(r[5:4], 2'b01)
		fb <= 12'd2000;
		per();
		per();
		`CHK(h inside {[20:26]}, 1'b1)
		`CHK(l inside {[5:20]}, 1'b1)
		rs <= 1'b0;
		per();
		per();
		`CHK(l inside {[1000:2003]}, 1'b1)
		rs <= 1'b1;
		ring <= 1'b0;
		per();
		per();
		`CHK(l inside {[1998:2004]}, 1'b1)
		ring <= 1'b1;
		tpk <= 8'd10;
		per();
		per();
		`CHK(h inside {[10:16]}, 1'b1)
		tpk <= 8'd200;
		tfb <= 8'd200;
		per();
		per();
		`CHK(h inside {[39:42]}, 1'b1)
		// Comparator high from the first on-cycle: only blanking keeps the pulse past three cycles
		tfb <= 8'd0;
		per();
		per();
		`CHK(h inside {[4:6]}, 1'b1)
		tfb <= 8'd20;
		apb(1'b0, qrsc_pkg::REG_CTRL, 32'h0);
		`CHK(r, 32'h1)
		apb(1'b1, qrsc_pkg::REG_CTRL, 32'h1);
		apb(1'b0, 12'hFFC, 32'h0);
		`CHK({e, r}, 33'h100000000)
		apb(1'b0, qrsc_pkg::REG_COUNTS, 32'h0);
		`CHK(r[3:0], 4'h1)
		hl <= 1'b1;
		w(60);
		apb(1'b0, qrsc_pkg::REG_COUNTS, 32'h0);
		`CHK({peak_limit_high, r[3:0]}, 5'h13)
		hl <= 1'b0;
		fb <= 12'd800;
		while (burst_active !== 1'b1) w(1);
		apb(1'b0, qrsc_pkg::REG_COUNTS, 32'h0);
		`CHK(r[3:0], 4'h8)
		quiet();
		`CHK(n, 0)
		fb <= 12'd2500;
		per();
		per();
		`CHK(h inside {[6:11]}, 1'b1)
		`CHK(l inside {[112:140]}, 1'b1)
		// Line change drops the up/down counter to 3, so ten valleys prove the fixed burst count
		hl <= 1'b1;
		per();
		per();
		`CHK(l inside {[144:170]}, 1'b1)
		hl <= 1'b0;
		fb <= 12'd1800;
		w(30);
		quiet();
		`CHK(n, 0)
		fb <= 12'd2800;
		w(6);
		smp();
		`CHK(burst_active, 1'b0)
		apb(1'b0, qrsc_pkg::REG_COUNTS, 32'h0);
		`CHK(r[3:0], 4'h1)
		rg <= 1'b0;
		von <= 1'b0;
		w(8);
		smp();
		`CHK({sel_source_en, fb_pullup_en}, 2'b10)
		w(1);
		rg <= 1'b1;
		fb <= 12'd500;
		von <= 1'b1;
		w(10);
		smp();
		`CHK(level_two, 1'b1)
		final_report();
	end
endmodule : qrsc_switch_ctrl_tb_top
`default_nettype wire
